/* rtl/gsb_defines.svh */
/*
 Constants for the global status byte and fail-safe control gating.
 Assumes inclusion by bare name from the rtl folder.
*/
`ifndef STATUS_BYTE_DEFINES_SVH
`define STATUS_BYTE_DEFINES_SVH

// Global status byte bit positions
`define SBYTE_BIT_FAILSAFE   24
`define SBYTE_BIT_WARNING    25
`define SBYTE_BIT_DEVERR     26
`define SBYTE_BIT_FUNCERR    27
`define SBYTE_BIT_PHYERR     28
`define SBYTE_BIT_SERERR     29
`define SBYTE_BIT_RESET      30
`define SBYTE_BIT_SUMMARY_N  31
`define SBYTE_RESET          8'h80

// Device-error flag vector layout
`define DEVERR_IDX_SUP_OV    0
`define DEVERR_IDX_SUP_UV    1
`define DEVERR_IDX_REG_OV    2
`define DEVERR_IDX_REG_UV    3
`define DEVERR_IDX_CHARGE_PUMP_LOW    4
`define DEVERR_IDX_CLUSTER   5
`define DEVERR_SUPPLY_COUNT  5

// Global-warning flag vector layout
`define WARN_IDX_REG_EW      0
`define WARN_IDX_REG1_F      1
`define WARN_IDX_REG2_F      2
`define WARN_IDX_TRX_LOW     3
`define WARN_IDX_THERMAL     4
`define WARN_IDX_INV_CMD     5
`define WARN_IDX_SCK_CNT     6
`define WARN_COUNT           7

// Control register addresses and fields
`define CTRL_ADDR_CR1      6'h01
`define CTRL_ADDR_CR2      6'h02
`define CTRL_ADDR_CR5      6'h05
`define CTRL_ADDR_CR6      6'h06
`define CTRL_ADDR_PWM_LO   6'h0C
`define CTRL_ADDR_PWM_HI   6'h11
`define CTRL_ADDR_KEEP_LO  6'h17
`define CTRL_ADDR_KEEP_HI  6'h1D
`define CTRL_ADDR_CONFIG   6'h3F
`define CR1_SAFE_WR_BITS   24'h000131
`define CR1_KEEP_BITS      24'h000080
`define CR2_SAFE_WR_BITS   24'hFFFF00
`define CR56_SAFE_WR_BITS  24'h00000F
`define CTRL_ALL_BITS      24'hFFFFFF
`define CTRL_NO_BITS       24'h000000

`endif

/* rtl/gsb_pkg.sv */
/*
 Types for the global status byte block.
 Assumes gsb_defines.svh is available for widths.
*/
`include "gsb_defines.svh"

package status_byte_pkg;

   typedef struct packed {
      logic       dev_err;
      logic       warn;
      logic       safe;
      logic       summary_n;
      logic [7:0] status_byte;
      logic       default_load;
   } summary_state_type;

   typedef struct packed {
      logic        go;
      logic [5:0]  addr;
      logic [23:0] data;
      logic [23:0] bits;
   } write_gate_state_type;

endpackage

/* rtl/sticky_flag_bank.sv */
/*
 Bank of sticky status flags, set by hardware events, cleared by read-and-clear.
 Assumes set and clear vectors are synchronous to clk_sys.
*/
`timescale 1ns/10ps

module sticky_flag_bank #(
   parameter int W = 7
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] set_bits,
   input  wire logic [W-1:0] clr_bits,
   output logic      [W-1:0] flags_ff,
   output logic      [W-1:0] nxt_flags
);

   typedef struct packed {
      logic [W-1:0] flags;
   } bank_state_type;

   bank_state_type state_ff;
   bank_state_type nxt_state;

   always_comb begin
      nxt_state = state_ff;
      // Set wins over a clear in the same cycle
      nxt_state.flags = (state_ff.flags & ~clr_bits) | set_bits;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign flags_ff  = state_ff.flags;
   assign nxt_flags = nxt_state.flags;

endmodule

/* rtl/safe_write_gate.sv */
/*
 Control register write gate: in the safe state only exempt bits may be written.
 Assumes the control register file applies wr_bits_ff as a per-bit write enable.
*/
`timescale 1ns/10ps
`include "gsb_defines.svh"

module safe_write_gate (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        safe_state,
   input  wire logic        wr_req,
   input  wire logic [5:0]  wr_addr,
   input  wire logic [23:0] wr_data,
   output logic             wr_go_ff,
   output logic      [5:0]  wr_addr_ff,
   output logic      [23:0] wr_data_ff,
   output logic      [23:0] wr_bits_ff
);

   status_byte_pkg::write_gate_state_type state_ff;
   status_byte_pkg::write_gate_state_type nxt_state;
   logic [23:0]                           allowed;

   always_comb begin
      allowed = `CTRL_ALL_BITS;
      if (safe_state) begin
         if (wr_addr == `CTRL_ADDR_CR1) begin
            allowed = `CR1_SAFE_WR_BITS;
         end else if (wr_addr == `CTRL_ADDR_CR2) begin
            allowed = `CR2_SAFE_WR_BITS;
         end else if (wr_addr == `CTRL_ADDR_CR5 || wr_addr == `CTRL_ADDR_CR6) begin
            allowed = `CR56_SAFE_WR_BITS;
         end else if (wr_addr >= `CTRL_ADDR_PWM_LO && wr_addr <= `CTRL_ADDR_PWM_HI) begin
            allowed = `CTRL_ALL_BITS;
         end else begin
            allowed = `CTRL_NO_BITS;
         end
      end
      nxt_state      = state_ff;
      nxt_state.go   = wr_req && (allowed != `CTRL_NO_BITS);
      nxt_state.addr = wr_addr;
      nxt_state.data = wr_data;
      nxt_state.bits = wr_req ? allowed : `CTRL_NO_BITS;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign wr_go_ff   = state_ff.go;
   assign wr_addr_ff = state_ff.addr;
   assign wr_data_ff = state_ff.data;
   assign wr_bits_ff = state_ff.bits;

endmodule

/* rtl/global_status_failsafe_flags.sv */
/*
 Upper global status byte: device-error, global-warning, fail-safe flags,
 the inverted global summary bit, and fail-safe control register effects.
 Assumes all inputs synchronous to clk_sys; the control register file honours
 ctrl_default_load (keeping watchdog enable and 0x17..0x1D) and wr_bits_ff.
*/
`timescale 1ns/10ps
`include "gsb_defines.svh"

module global_status_failsafe_flags #(
   parameter int CLUSTERS = 4
) (
   input  wire logic                 clk_sys,
   input  wire logic                 rst_n,
   input  wire logic                 supply_overvoltage,
   input  wire logic                 supply_undervoltage,
   input  wire logic                 reg_supply_overvoltage,
   input  wire logic                 reg_supply_undervoltage,
   input  wire logic                 charge_pump_low,
   input  wire logic [CLUSTERS-1:0]  cluster_thermal_shutdown,
   input  wire logic [`DEVERR_SUPPLY_COUNT+CLUSTERS-1:0] dev_clear,
   input  wire logic                 reg_supply_early_warning,
   input  wire logic                 first_regulator_fail,
   input  wire logic                 second_regulator_fail,
   input  wire logic                 transceiver_supply_low,
   input  wire logic                 thermal_warning,
   input  wire logic                 invalid_serial_command,
   input  wire logic                 wrong_serial_clock_count,
   input  wire logic [`WARN_COUNT-1:0] warn_clear,
   input  wire logic                 watchdog_failure,
   input  wire logic                 first_regulator_undervoltage,
   input  wire logic                 second_level_thermal_shutdown,
   input  wire logic                 forced_sleep_thermal_or_short,
   input  wire logic                 fail_safe_exit,
   input  wire logic                 reset_flag,
   input  wire logic                 serial_error_flag,
   input  wire logic                 phys_layer_error_flag,
   input  wire logic                 functional_error_other,
   input  wire logic                 open_load_error,
   input  wire logic                 mask_global_warning,
   input  wire logic                 mask_open_load,
   input  wire logic                 mask_thermal_warning,
   input  wire logic                 ctrl_wr_req,
   input  wire logic [5:0]           ctrl_wr_addr,
   input  wire logic [23:0]          ctrl_wr_data,
   output logic                      device_error_flag,
   output logic                      global_warning_flag,
   output logic                      fail_safe_flag,
   output logic                      inverted_global_summary,
   output logic [7:0]                global_status_byte,
   output logic [`DEVERR_SUPPLY_COUNT+CLUSTERS-1:0] dev_flags,
   output logic [`WARN_COUNT-1:0]    warn_flags,
   output logic                      ctrl_default_load,
   output logic                      ctrl_wr_go,
   output logic [5:0]                ctrl_wr_addr_out,
   output logic [23:0]               ctrl_wr_data_out,
   output logic [23:0]               ctrl_wr_bits
);

   localparam int DW = `DEVERR_SUPPLY_COUNT + CLUSTERS;

   status_byte_pkg::summary_state_type state_ff;
   status_byte_pkg::summary_state_type nxt_state;

   logic [DW-1:0]          dev_set;
   logic [DW-1:0]          nxt_dev;
   logic [`WARN_COUNT-1:0] warn_set;
   logic [`WARN_COUNT-1:0] nxt_warn;
   logic [`WARN_COUNT-1:0] warn_sum_bits;
   logic                   safe_cause;
   logic                   safe_hold;
   logic                   safe_entry;
   logic                   func_err;
   logic                   func_err_sum;
   logic                   warn_sum;
   logic                   dev_any;
   logic                   warn_any;
   logic                   upper_any;
   logic [7:0]             byte_next;

   // Device-error contributors
   always_comb begin
      dev_set                           = '0;
      dev_set[`DEVERR_IDX_SUP_OV]       = supply_overvoltage;
      dev_set[`DEVERR_IDX_SUP_UV]       = supply_undervoltage;
      dev_set[`DEVERR_IDX_REG_OV]       = reg_supply_overvoltage;
      dev_set[`DEVERR_IDX_REG_UV]       = reg_supply_undervoltage;
      dev_set[`DEVERR_IDX_CHARGE_PUMP_LOW]       = charge_pump_low;
      dev_set[DW-1:`DEVERR_IDX_CLUSTER] = cluster_thermal_shutdown;
   end

   // Warning contributors
   always_comb begin
      warn_set                     = '0;
      warn_set[`WARN_IDX_REG_EW]   = reg_supply_early_warning;
      warn_set[`WARN_IDX_REG1_F]   = first_regulator_fail;
      warn_set[`WARN_IDX_REG2_F]   = second_regulator_fail;
      warn_set[`WARN_IDX_TRX_LOW]  = transceiver_supply_low;
      warn_set[`WARN_IDX_THERMAL]  = thermal_warning;
      warn_set[`WARN_IDX_INV_CMD]  = invalid_serial_command;
      warn_set[`WARN_IDX_SCK_CNT]  = wrong_serial_clock_count;
   end

   sticky_flag_bank #(
      .W (DW)
   ) dev_bank (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .set_bits  (dev_set),
      .clr_bits  (dev_clear),
      .flags_ff  (dev_flags),
      .nxt_flags (nxt_dev)
   );

   sticky_flag_bank #(
      .W (`WARN_COUNT)
   ) warn_bank (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .set_bits  (warn_set),
      .clr_bits  (warn_clear),
      .flags_ff  (warn_flags),
      .nxt_flags (nxt_warn)
   );

   safe_write_gate write_gate (
      .clk_sys    (clk_sys),
      .rst_n      (rst_n),
      .safe_state (state_ff.safe),
      .wr_req     (ctrl_wr_req),
      .wr_addr    (ctrl_wr_addr),
      .wr_data    (ctrl_wr_data),
      .wr_go_ff   (ctrl_wr_go),
      .wr_addr_ff (ctrl_wr_addr_out),
      .wr_data_ff (ctrl_wr_data_out),
      .wr_bits_ff (ctrl_wr_bits)
   );

   // Fail-safe causes
   always_comb begin
      safe_cause = watchdog_failure
                 | first_regulator_undervoltage
                 | second_level_thermal_shutdown
                 | forced_sleep_thermal_or_short;
   end

   // Cause holds the flag; exit clears it only with no cause present
   always_comb begin
      safe_hold  = safe_cause | (state_ff.safe & ~fail_safe_exit);
      safe_entry = safe_hold & ~state_ff.safe;
   end

   // Functional error and its masked share
   always_comb begin
      func_err     = functional_error_other | open_load_error;
      func_err_sum = functional_error_other | (open_load_error & ~mask_open_load);
   end

   // Warning share of the inverted summary
   always_comb begin
      warn_sum_bits = nxt_warn;
      if (mask_thermal_warning) begin
         warn_sum_bits[`WARN_IDX_THERMAL] = 1'b0;
      end
      warn_sum = (|warn_sum_bits) & ~mask_global_warning;
   end

   // Summaries from next flag values, so they match the flag registers
   always_comb begin
      dev_any   = |nxt_dev;
      // Warnings feed this flag and, through warn_sum, the inverted summary
      warn_any  = |nxt_warn;
      upper_any = reset_flag | serial_error_flag | phys_layer_error_flag
                | func_err_sum | dev_any | warn_sum | safe_hold;
   end

   // Status byte assembly
   always_comb begin
      byte_next = '0;
      byte_next[`SBYTE_BIT_SUMMARY_N - `SBYTE_BIT_FAILSAFE] = ~upper_any;
      byte_next[`SBYTE_BIT_RESET - `SBYTE_BIT_FAILSAFE]     = reset_flag;
      byte_next[`SBYTE_BIT_SERERR - `SBYTE_BIT_FAILSAFE]    = serial_error_flag;
      byte_next[`SBYTE_BIT_PHYERR - `SBYTE_BIT_FAILSAFE]    = phys_layer_error_flag;
      byte_next[`SBYTE_BIT_FUNCERR - `SBYTE_BIT_FAILSAFE]   = func_err;
      byte_next[`SBYTE_BIT_DEVERR - `SBYTE_BIT_FAILSAFE]    = dev_any;
      byte_next[`SBYTE_BIT_WARNING - `SBYTE_BIT_FAILSAFE]   = warn_any;
      byte_next[`SBYTE_BIT_FAILSAFE - `SBYTE_BIT_FAILSAFE]  = safe_hold;
   end

   // Next state
   always_comb begin
      nxt_state              = state_ff;
      nxt_state.dev_err      = dev_any;
      nxt_state.warn         = warn_any;
      nxt_state.safe         = safe_hold;
      nxt_state.default_load = safe_entry;
      nxt_state.summary_n    = ~upper_any;
      nxt_state.status_byte  = byte_next;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_ff             <= '0;
         state_ff.summary_n   <= 1'b1;
         state_ff.status_byte <= `SBYTE_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign device_error_flag       = state_ff.dev_err;
   assign global_warning_flag     = state_ff.warn;
   assign fail_safe_flag          = state_ff.safe;
   assign inverted_global_summary = state_ff.summary_n;
   assign global_status_byte      = state_ff.status_byte;
   assign ctrl_default_load       = state_ff.default_load;

endmodule

/* verification/gsb_flags_assertions.sv */
/*
 Checker for the global status flags block: summaries, fail-safe and write gate.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
`include "gsb_defines.svh"

module status_flags_assertions #(
   parameter int CLUSTERS = 4
) (
   input wire logic                                clk_sys,
   input wire logic                                rst_n,
   input wire logic [`DEVERR_SUPPLY_COUNT+CLUSTERS-1:0] dev_clear,
   input wire logic                                watchdog_failure,
   input wire logic                                first_regulator_undervoltage,
   input wire logic                                second_level_thermal_shutdown,
   input wire logic                                forced_sleep_thermal_or_short,
   input wire logic                                fail_safe_exit,
   input wire logic                                ctrl_wr_req,
   input wire logic [5:0]                          ctrl_wr_addr,
   input wire logic                                device_error_flag,
   input wire logic                                global_warning_flag,
   input wire logic                                fail_safe_flag,
   input wire logic                                inverted_global_summary,
   input wire logic [7:0]                          global_status_byte,
   input wire logic [`DEVERR_SUPPLY_COUNT+CLUSTERS-1:0] dev_flags,
   input wire logic [`WARN_COUNT-1:0]              warn_flags,
   input wire logic                                ctrl_default_load,
   input wire logic                                ctrl_wr_go,
   input wire logic [23:0]                         ctrl_wr_bits
);
   wire logic cause = watchdog_failure | first_regulator_undervoltage |
                      second_level_thermal_shutdown | forced_sleep_thermal_or_short;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_entry;
      cause && !fail_safe_flag;
   endsequence
   sequence s_load_pulse;
      fail_safe_flag && ctrl_default_load ##1 !ctrl_default_load;
   endsequence

   a_dev_summary: assert property (device_error_flag == |dev_flags)
      else $error("device error differs from its flags");
   a_warn_summary: assert property (global_warning_flag == |warn_flags)
      else $error("global warning differs from its flags");
   a_dev_sticky: assert property (1'b1 |=> (($past(dev_flags) & ~$past(dev_clear) & ~dev_flags) == '0))
      else $error("device flag dropped without clear");
   a_safe_entry: assert property (s_entry |=> s_load_pulse)
      else $error("fail-safe entry or default load wrong");
   a_safe_hold: assert property (fail_safe_flag && (!fail_safe_exit || cause) |=> fail_safe_flag)
      else $error("fail-safe dropped while safe state lasts");
   a_safe_cause_only: assert property (!fail_safe_flag && !cause |=> !fail_safe_flag && !ctrl_default_load)
      else $error("fail-safe set without a cause");
   a_gate_block: assert property (ctrl_wr_req && fail_safe_flag && ctrl_wr_addr == 6'h03
                                  |=> !ctrl_wr_go && ctrl_wr_bits == 24'h000000)
      else $error("blocked write passed in fail-safe");
   a_gate_open: assert property (ctrl_wr_req && !fail_safe_flag |=> ctrl_wr_go && ctrl_wr_bits == 24'hFFFFFF)
      else $error("write not passed outside fail-safe");
   a_summary_byte: assert property (inverted_global_summary == global_status_byte[7] &&
                                    (global_status_byte[6:0] != 7'h00 || inverted_global_summary))
      else $error("inverted summary wrong");
   a_byte_map: assert property (global_status_byte[2:0] ==
                                {device_error_flag, global_warning_flag, fail_safe_flag})
      else $error("status byte fields misplaced");
endmodule

bind global_status_failsafe_flags status_flags_assertions #(.CLUSTERS(CLUSTERS)) u_chk (
   .clk_sys, .rst_n, .dev_clear, .watchdog_failure, .first_regulator_undervoltage,
   .second_level_thermal_shutdown, .forced_sleep_thermal_or_short, .fail_safe_exit, .ctrl_wr_req,
   .ctrl_wr_addr, .device_error_flag, .global_warning_flag, .fail_safe_flag, .inverted_global_summary,
   .global_status_byte, .dev_flags, .warn_flags, .ctrl_default_load, .ctrl_wr_go, .ctrl_wr_bits);

/* verification/tb_global_status_failsafe_flags.sv */
/*
 Testbench for the global status flags block: set, clear, mask, fail-safe, writes.
 Assumes design and checker are compiled first; CLUSTERS left at 4.
*/
`timescale 1ns/10ps
`include "gsb_defines.svh"

module tb_global_status_failsafe_flags;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic [8:0]  dset = 9'h000, dclr = 9'h000, dfl;
   logic [6:0]  wset = 7'h00, wclr = 7'h00, wfl;
   logic [3:0]  fset = 4'h0, lv = 4'h0;
   logic [2:0]  m = 3'h0;
   logic        fx = 1'b0, ol = 1'b0, wreq = 1'b0;
   logic [5:0]  wa = 6'h00, ao;
   logic [23:0] wd = 24'h000000, dout, bits;
   logic [7:0]  sbyte;
   logic        derr, warn, safe, sumn, dl, go;
   logic [5:0]  at [8] = '{6'h01, 6'h02, 6'h05, 6'h06, 6'h0C, 6'h11, 6'h03, 6'h17};
   logic [23:0] bt [8] = '{24'h000131, 24'hFFFF00, 24'h00000F, 24'h00000F, 24'hFFFFFF, 24'hFFFFFF,
                           24'h000000, 24'h000000};
   logic [2:0]  mt [3] = '{3'h1, 3'h4, 3'h2};
   logic [6:0]  wt [3] = '{7'h10, 7'h20, 7'h00};
   int          fail_count = 0;
   int          n_compared = 0;
   int          i;

   global_status_failsafe_flags uut (
      .clk_sys(clk_sys), .rst_n(rst_n), .supply_overvoltage(dset[0]), .supply_undervoltage(dset[1]),
      .reg_supply_overvoltage(dset[2]), .reg_supply_undervoltage(dset[3]), .charge_pump_low(dset[4]),
      .cluster_thermal_shutdown(dset[8:5]), .dev_clear(dclr), .reg_supply_early_warning(wset[0]),
      .first_regulator_fail(wset[1]), .second_regulator_fail(wset[2]), .transceiver_supply_low(wset[3]),
      .thermal_warning(wset[4]), .invalid_serial_command(wset[5]), .wrong_serial_clock_count(wset[6]),
      .warn_clear(wclr), .watchdog_failure(fset[0]), .first_regulator_undervoltage(fset[1]),
      .second_level_thermal_shutdown(fset[2]), .forced_sleep_thermal_or_short(fset[3]),
      .fail_safe_exit(fx), .reset_flag(lv[3]), .serial_error_flag(lv[2]), .phys_layer_error_flag(lv[1]),
      .functional_error_other(lv[0]), .open_load_error(ol), .mask_global_warning(m[2]),
      .mask_open_load(m[1]), .mask_thermal_warning(m[0]), .ctrl_wr_req(wreq), .ctrl_wr_addr(wa),
      .ctrl_wr_data(wd), .device_error_flag(derr), .global_warning_flag(warn), .fail_safe_flag(safe),
      .inverted_global_summary(sumn), .global_status_byte(sbyte), .dev_flags(dfl), .warn_flags(wfl),
      .ctrl_default_load(dl), .ctrl_wr_go(go), .ctrl_wr_addr_out(ao), .ctrl_wr_data_out(dout),
      .ctrl_wr_bits(bits));

   always #2 clk_sys = ~clk_sys;

   task automatic chk(input logic [23:0] s, input logic [23:0] e);
      n_compared++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic p(input logic [8:0] d, c, input logic [6:0] w, x, input logic [3:0] f, input logic e);
      @(posedge clk_sys);
      {dset, dclr, wset, wclr, fset, fx} <= {d, c, w, x, f, e};
      @(posedge clk_sys);
      {dset, dclr, wset, wclr, fset, fx} <= '0;
      #1;
   endtask

   task automatic wr(input logic [5:0] a, input logic [23:0] b);
      @(posedge clk_sys);
      {wreq, wa, wd} <= {1'b1, a, 18'h2D2D2, a};
      @(posedge clk_sys);
      wreq <= 1'b0;
      #1;
      chk(bits, b);
      chk(go, b != 24'h000000);
      if (b != 24'h000000) chk({ao, dout}, {a, 18'h2D2D2, a});
   endtask

   task automatic finish_test;
      $display("mismatches %0d compared %0d", fail_count, n_compared);
      if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #100000;
      fail_count++;
      finish_test;
   end

   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      #1;
      chk({derr, warn, safe, sumn, sbyte}, 12'h180);
      for (i = 0; i < 9; i++) begin
         p(9'h001 << i, 0, 0, 0, 0, 0);
         chk({dfl, derr, sumn, sbyte[2]}, {9'h001 << i, 3'b101});
         p(0, 9'h001 << i, 0, 0, 0, 0);
         chk({derr, sumn}, 2'b01);
      end
      p(9'h003, 0, 0, 0, 0, 0);
      p(9'h002, 9'h003, 0, 0, 0, 0);
      chk({dfl, derr}, {9'h002, 1'b1});
      p(0, 9'h002, 0, 0, 0, 0);
      chk(derr, 0);
      for (i = 0; i < 7; i++) begin
         p(0, 0, 7'h01 << i, 0, 0, 0);
         chk({wfl, warn, sumn, sbyte[1], safe, dl}, {7'h01 << i, 5'b10100});
         p(0, 0, 0, 7'h01 << i, 0, 0);
         chk({warn, sumn}, 2'b01);
      end
      for (i = 0; i < 3; i++) begin
         @(posedge clk_sys);
         {m, ol} <= {mt[i], i == 2};
         p(0, 0, wt[i], 0, 0, 0);
         chk({warn | sbyte[3], sumn}, 2'b11);
         @(posedge clk_sys);
         m <= 3'h0;
         @(posedge clk_sys);
         #1;
         chk(sumn, 0);
         @(posedge clk_sys);
         ol <= 1'b0;
         p(0, 0, 0, wt[i], 0, 0);
         chk(sumn, 1);
      end
      for (i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         lv <= 4'h1 << i;
         @(posedge clk_sys);
         #1;
         chk({sbyte[6:3], sumn}, {4'h1 << i, 1'b0});
      end
      @(posedge clk_sys);
      lv <= 4'h0;
      for (i = 0; i < 4; i++) begin
         p(0, 0, 0, 0, 4'h1 << i, 0);
         chk({safe, dl, sumn, sbyte[0]}, 4'b1101);
         repeat (6) @(posedge clk_sys);
         #1;
         chk({safe, dl}, 2'b10);
         if (i == 0) for (int t = 0; t < 8; t++) wr(at[t], bt[t]);
         p(0, 0, 0, 0, 4'h1 << i, 1);
         chk(safe, 1);
         p(0, 0, 0, 0, 0, 1);
         chk({safe, sumn}, 2'b01);
      end
      wr(6'h03, 24'hFFFFFF);
      finish_test;
   end
endmodule
